// ---- hw/mrid_params.svh ----
/*
  Constants of the mid-range instruction decoder: timing, instruction field
  positions, group codes, special instruction words and reset values.
  Assumes it is included by its bare name from the core.
*/
`ifndef MRID_PARAMS_SVH
`define MRID_PARAMS_SVH

// ============================================================
// timing
// ============================================================
// oscillator periods (clock cycles) in one instruction cycle
`define MRID_OSC_PER_CYCLE 4

// ============================================================
// instruction word fields
// ============================================================
`define MRID_IR_W         14
`define MRID_CLASS_HI     13
`define MRID_CLASS_LO     12
`define MRID_DEST_BIT     7
`define MRID_CALL_BIT     11
`define MRID_CLASS_BYTE   2'b00
`define MRID_CLASS_BIT    2'b01
`define MRID_CLASS_JUMP   2'b10
`define MRID_CLASS_LIT    2'b11

// ============================================================
// control words of the byte group with d = 0 (low byte)
// ============================================================
`define MRID_MISC_RETURN  8'h08
`define MRID_MISC_RETFIE  8'h09
`define MRID_MISC_SLEEP   8'h63
`define MRID_MISC_WDTCLR  8'h64

// ============================================================
// reset values
// ============================================================
`define MRID_RESET_PC     13'h0000
`define MRID_RESET_IR     14'h0000
`define MRID_RESET_W      8'h00

`endif

// ---- hw/mrid_pkg.sv ----
/*
  Types of the mid-range instruction decoder: quarter-cycle phases and the
  operation codes of the byte and bit groups.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mrid_pkg;

  // ============================================================
  // quarter phases, gray coded along Q1-Q2-Q3-Q4
  // ============================================================
  typedef enum logic [1:0] {
    MRID_Q1 = 2'b00,
    MRID_Q2 = 2'b01,
    MRID_Q3 = 2'b11,
    MRID_Q4 = 2'b10
  } mrid_phase_t;

  // ============================================================
  // byte-oriented operation codes, bits 11:8
  // ============================================================
  typedef enum logic [3:0] {
    MRID_BOP_MISC  = 4'h0,
    MRID_BOP_CLR   = 4'h1,
    MRID_BOP_SUB   = 4'h2,
    MRID_BOP_DEC   = 4'h3,
    MRID_BOP_IOR   = 4'h4,
    MRID_BOP_AND   = 4'h5,
    MRID_BOP_XOR   = 4'h6,
    MRID_BOP_ADD   = 4'h7,
    MRID_BOP_MOV   = 4'h8,
    MRID_BOP_COM   = 4'h9,
    MRID_BOP_INC   = 4'hA,
    MRID_BOP_DECSZ = 4'hB,
    MRID_BOP_RR    = 4'hC,
    MRID_BOP_RL    = 4'hD,
    MRID_BOP_SWAP  = 4'hE,
    MRID_BOP_INCSZ = 4'hF
  } mrid_bop_t;

  // ============================================================
  // bit-oriented operation codes, bits 11:10
  // ============================================================
  typedef enum logic [1:0] {
    MRID_BIT_CLR = 2'b00,
    MRID_BIT_SET = 2'b01,
    MRID_BIT_TSC = 2'b10,
    MRID_BIT_TSS = 2'b11
  } mrid_bitop_t;

endpackage : mrid_pkg

// ---- hw/mrid_file_ram.sv ----
/*
  File register memory of the decoder: one write port, one read port whose
  data comes out of a register one clock after the address.
  Assumes a single clock; contents are not cleared by reset.
*/
`timescale 1ns/100ps

module mrid_file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  // write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // ============================================================
  // storage
  // ============================================================
  // no reset on the array, so it maps onto plain memory
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // registered read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule : mrid_file_ram

// ---- hw/mrid_core.sv ----
/*
  Instruction decoder and executor of an 8-bit core with 14-bit words.
  Holds the working register, the flags, the program counter, the quarter
  phase sequencer and the file register memory.
  Assumes: instruction words arrive on INSTR_IN for the address on PC_OUT
  and are sampled at the end of Q4; the stack and the watchdog live outside;
  all inputs are synchronous to CLK_IN.
  // Operation
  // - one instruction cycle is four clocks (4 MHz gives 1 us)
  // - one cycle per instruction; skips and branches add a NOP cycle
  // - byte ops: d=0 result to W, d=1 back to the file register
  // - 00 0111 adds W and file; updates carry, digit carry, zero
  // - 00 0101 ANDs W with file; updates zero only
  // - 11 111x adds literal to W; updates carry, digit carry, zero
  // - 01 00bb clears the selected file bit; flags untouched
  // - 01 01bb sets the selected file bit; flags untouched
  // - 01 10bb skips the next instruction when the bit is zero
  // - 01 11bb skips the next instruction when the bit is one
  // - clear-file writes zero to the file register and sets zero flag
  // - read-modify-write of a port reads the pin levels
  // - writing the timer-zero count clears its prescaler if assigned
  // - don't-care bits never change the decoding
  // - the 3-bit selector picks one of eight file register bits
  // - every word falls in byte, bit or literal/control group
  // - file address is seven bits, 0 to 127 in the bank
  // - call pushes return address, loads 11 bits plus page latch
  // - decrement/increment-skip skip the next word on zero result
  // - standby clears watchdog, clears power-down, sets timeout, stops
*/
`timescale 1ns/100ps

`include "mrid_params.svh"

module mrid_core #(
  parameter int         FILE_AW   = 7,
  parameter logic [6:0] TIMER_ZERO_COUNT_ADDR = 7'h01,
  parameter logic [6:0] PORT_LO   = 7'h05,
  parameter logic [6:0] PORT_HI   = 7'h09
) (
  // clock and reset
  input  wire logic                       CLK_IN,
  input  wire logic                       NRST_IN,
  // program memory
  input  wire logic [`MRID_IR_W-1:0]      INSTR_IN,
  input  wire logic [1:0]                 PAGE_IN,
  output logic      [12:0]                PC_OUT,
  // stack
  input  wire logic [12:0]                TOS_IN,
  output logic                            PUSH_OUT,
  output logic                            POP_OUT,
  output logic      [12:0]                RET_ADDR_OUT,
  // port pins and timer side
  input  wire logic [7:0]                 PINS_IN,
  input  wire logic                       PRESC_TIMER_ZERO_COUNT_IN,
  input  wire logic                       WAKE_IN,
  output logic      [FILE_AW-1:0]         FILE_ADDR_OUT,
  output logic                            PRESC_CLR_OUT,
  output logic                            WDT_CLR_OUT,
  // core state
  output logic      [7:0]                 W_OUT,
  output logic                            CARRY_OUT,
  output logic                            DIGIT_CARRY_FLAG_OUT,
  output logic                            ZERO_OUT,
  output logic                            TIMEOUT_FLAG_OUT,
  output logic                            POWERDOWN_FLAG_OUT,
  output logic                            SLEEP_OUT,
  output logic                            CYCLE_END_OUT,
  output logic                            NOP_CYCLE_OUT
);
  import mrid_pkg::*;

  // ============================================================
  // state
  // ============================================================
  mrid_phase_t       ph_q, ph_d;
  logic [13:0]       ir_q;
  logic [12:0]       pc_q;
  logic [7:0]        w_q;
  logic              c_q, dc_q, z_q, to_q, pd_q;
  logic              nop_q, asleep_q, end_q;
  logic              push_q, pop_q, presc_q, wdt_q;
  logic [12:0]       ret_q;
  logic [7:0]        rdata;

  // ============================================================
  // field decode
  // ============================================================
  wire [1:0]   iclass   = ir_q[`MRID_CLASS_HI:`MRID_CLASS_LO];
  wire         is_byte  = (iclass == `MRID_CLASS_BYTE);
  wire         is_bit   = (iclass == `MRID_CLASS_BIT);
  wire         is_lit   = (iclass == `MRID_CLASS_LIT);
  wire         dest     = ir_q[`MRID_DEST_BIT];
  wire [FILE_AW-1:0] fa = ir_q[FILE_AW-1:0];
  wire [2:0]   bsel     = ir_q[9:7];
  wire [7:0]   kval     = ir_q[7:0];
  wire [7:0]   bmask    = 8'h01 << bsel;
  wire         is_port  = (fa >= PORT_LO) && (fa <= PORT_HI);
  mrid_bop_t   bop;
  mrid_bitop_t bitop;
  assign bop   = mrid_bop_t'(ir_q[11:8]);
  assign bitop = mrid_bitop_t'(ir_q[11:10]);

  // ports read back as pin levels, not as the stored latch
  wire [7:0]   fval  = is_port ? PINS_IN : rdata;
  wire [7:0]   opnd  = is_lit ? kval : fval;

  // arithmetic shared by file and literal forms
  wire [8:0]   add_s  = {1'b0, w_q} + {1'b0, opnd};
  wire [4:0]   add_dc = {1'b0, w_q[3:0]} + {1'b0, opnd[3:0]};
  wire [8:0]   sub_s  = {1'b0, opnd} + {1'b0, ~w_q} + 9'h001;
  wire [4:0]   sub_dc = {1'b0, opnd[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
  wire [7:0]   inc_v  = fval + 8'h01;
  wire [7:0]   dec_v  = fval - 8'h01;
  wire         bit_on = |(fval & bmask);

  // ============================================================
  // execute: result, destinations, flag updates, flow control
  // ============================================================
  logic [7:0]  res;
  logic [12:0] pc_tgt;
  logic        wr_w, wr_f, z_up, c_up, dc_up, c_new, dc_new;
  logic        skip, jump, push, pop, do_sleep, do_wdt;

  always_comb begin
    res = fval; wr_w = 1'b0; wr_f = 1'b0; pc_tgt = pc_q;
    z_up = 1'b0; c_up = 1'b0; dc_up = 1'b0; c_new = c_q; dc_new = dc_q;
    skip = 1'b0; jump = 1'b0; push = 1'b0; pop = 1'b0;
    do_sleep = 1'b0; do_wdt = 1'b0;
    case (iclass)
      `MRID_CLASS_BYTE: begin
        wr_w = ~dest;
        wr_f = dest;
        case (bop)
          MRID_BOP_MISC: begin
            wr_w = 1'b0;
            res  = w_q;
            if (!dest) begin
              if (kval == `MRID_MISC_RETURN || kval == `MRID_MISC_RETFIE) begin
                pop = 1'b1; jump = 1'b1; pc_tgt = TOS_IN;
              end
              do_sleep = (kval == `MRID_MISC_SLEEP);
              do_wdt   = (kval == `MRID_MISC_WDTCLR);
            end
          end
          MRID_BOP_CLR: begin
            res = 8'h00; z_up = 1'b1;
          end
          MRID_BOP_SUB: begin
            res = sub_s[7:0]; c_new = sub_s[8]; dc_new = sub_dc[4];
            z_up = 1'b1; c_up = 1'b1; dc_up = 1'b1;
          end
          MRID_BOP_DEC: begin res = dec_v; z_up = 1'b1; end
          MRID_BOP_IOR: begin res = w_q | fval; z_up = 1'b1; end
          MRID_BOP_AND: begin res = w_q & fval; z_up = 1'b1; end
          MRID_BOP_XOR: begin res = w_q ^ fval; z_up = 1'b1; end
          MRID_BOP_ADD: begin
            res = add_s[7:0]; c_new = add_s[8]; dc_new = add_dc[4];
            z_up = 1'b1; c_up = 1'b1; dc_up = 1'b1;
          end
          MRID_BOP_MOV: begin res = fval; z_up = 1'b1; end
          MRID_BOP_COM: begin res = ~fval; z_up = 1'b1; end
          MRID_BOP_INC: begin res = inc_v; z_up = 1'b1; end
          MRID_BOP_DECSZ: begin
            res = dec_v; skip = (dec_v == 8'h00);
          end
          MRID_BOP_RR: begin
            res = {c_q, fval[7:1]}; c_new = fval[0]; c_up = 1'b1;
          end
          MRID_BOP_RL: begin
            res = {fval[6:0], c_q}; c_new = fval[7]; c_up = 1'b1;
          end
          MRID_BOP_SWAP: res = {fval[3:0], fval[7:4]};
          MRID_BOP_INCSZ: begin
            res = inc_v; skip = (inc_v == 8'h00);
          end
          default: res = fval;
        endcase
      end
      `MRID_CLASS_BIT: begin
        case (bitop)
          MRID_BIT_CLR: begin res = fval & ~bmask; wr_f = 1'b1; end
          MRID_BIT_SET: begin res = fval | bmask; wr_f = 1'b1; end
          MRID_BIT_TSC: skip = ~bit_on;
          MRID_BIT_TSS: skip = bit_on;
          default: skip = 1'b0;
        endcase
      end
      `MRID_CLASS_JUMP: begin
        jump   = 1'b1;
        push   = ~ir_q[`MRID_CALL_BIT];
        pc_tgt = {PAGE_IN, ir_q[10:0]};
      end
      default: begin
        // literal group; the x positions are left out of the match
        wr_w = 1'b1;
        casez (ir_q[11:8])
          4'b00??: res = kval;
          4'b01??: begin
            res = kval; pop = 1'b1; jump = 1'b1; pc_tgt = TOS_IN;
          end
          4'b1000: begin res = w_q | kval; z_up = 1'b1; end
          4'b1001: begin res = w_q & kval; z_up = 1'b1; end
          4'b1010: begin res = w_q ^ kval; z_up = 1'b1; end
          4'b110?: begin
            res = sub_s[7:0]; c_new = sub_s[8]; dc_new = sub_dc[4];
            z_up = 1'b1; c_up = 1'b1; dc_up = 1'b1;
          end
          4'b111?: begin
            res = add_s[7:0]; c_new = add_s[8]; dc_new = add_dc[4];
            z_up = 1'b1; c_up = 1'b1; dc_up = 1'b1;
          end
          default: wr_w = 1'b0;
        endcase
      end
    endcase
  end

  // ============================================================
  // quarter sequencer
  // ============================================================
  // the phase freezes at Q1 in standby, which stands in for the stopped
  // oscillator; nothing executes until WAKE_IN
  always_comb begin
    case (ph_q)
      MRID_Q1: ph_d = asleep_q ? MRID_Q1 : MRID_Q2;
      MRID_Q2: ph_d = MRID_Q3;
      MRID_Q3: ph_d = MRID_Q4;
      MRID_Q4: ph_d = MRID_Q1;
      default: ph_d = MRID_Q1;
    endcase
  end

  wire cycle_end = (ph_q == MRID_Q4);
  wire exec      = cycle_end & ~nop_q;
  wire f_write   = exec & wr_f;
  wire timer_zero_count_hit  = f_write && (fa == TIMER_ZERO_COUNT_ADDR) && PRESC_TIMER_ZERO_COUNT_IN;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ph_q <= MRID_Q1;
    end else begin
      ph_q <= ph_d;
    end
  end

  // ============================================================
  // instruction pipeline and program counter
  // ============================================================
  // the word fetched while a skip or branch executes is dropped and that
  // cycle runs as a NOP, giving two cycles in all
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ir_q  <= `MRID_RESET_IR;
      pc_q  <= `MRID_RESET_PC;
      nop_q <= 1'b1;
    end else if (cycle_end) begin
      ir_q  <= INSTR_IN;
      nop_q <= exec & (skip | jump);
      pc_q  <= (exec & jump) ? pc_tgt : pc_q + 13'h0001;
    end
  end

  // ============================================================
  // working register and arithmetic flags
  // ============================================================
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      w_q  <= `MRID_RESET_W;
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      z_q  <= 1'b0;
    end else if (exec) begin
      if (wr_w)  w_q  <= res;
      if (z_up)  z_q  <= (res == 8'h00);
      if (c_up)  c_q  <= c_new;
      if (dc_up) dc_q <= dc_new;
    end
  end

  // ============================================================
  // timeout, power-down and standby
  // ============================================================
  // both flags read one after power-up; a wake request in the very cycle
  // that standby executes is too early and is ignored
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      to_q     <= 1'b1;
      pd_q     <= 1'b1;
      asleep_q <= 1'b0;
    end else begin
      if (exec & (do_sleep | do_wdt)) begin
        to_q <= 1'b1;
        pd_q <= do_wdt;
      end
      if (exec & do_sleep) begin
        asleep_q <= 1'b1;
      end else if (WAKE_IN) begin
        asleep_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // one-cycle side pulses
  // ============================================================
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      push_q  <= 1'b0;
      pop_q   <= 1'b0;
      presc_q <= 1'b0;
      wdt_q   <= 1'b0;
      end_q   <= 1'b0;
      ret_q   <= `MRID_RESET_PC;
    end else begin
      push_q  <= exec & push;
      pop_q   <= exec & pop;
      presc_q <= timer_zero_count_hit;
      wdt_q   <= exec & (do_sleep | do_wdt);
      end_q   <= cycle_end;
      if (exec & push) ret_q <= pc_q;
    end
  end

  // ============================================================
  // file registers
  // ============================================================
  // the read is addressed straight from the held word, so data is settled
  // long before the Q4 write-back
  mrid_file_ram #(
    .AW (FILE_AW),
    .DW (8)
  ) u_file (
    .clk_in    (CLK_IN),
    .nrst_in   (NRST_IN),
    .we_in     (f_write),
    .waddr_in  (fa),
    .wdata_in  (res),
    .raddr_in  (fa),
    .rdata_out (rdata)
  );

  // ============================================================
  // outputs
  // ============================================================
  assign PC_OUT               = pc_q;
  assign PUSH_OUT             = push_q;
  assign POP_OUT              = pop_q;
  assign RET_ADDR_OUT         = ret_q;
  assign FILE_ADDR_OUT        = ir_q[FILE_AW-1:0];
  assign PRESC_CLR_OUT        = presc_q;
  assign WDT_CLR_OUT          = wdt_q;
  assign W_OUT                = w_q;
  assign CARRY_OUT            = c_q;
  assign DIGIT_CARRY_FLAG_OUT = dc_q;
  assign ZERO_OUT             = z_q;
  assign TIMEOUT_FLAG_OUT     = to_q;
  assign POWERDOWN_FLAG_OUT   = pd_q;
  assign SLEEP_OUT            = asleep_q;
  assign CYCLE_END_OUT        = end_q;
  assign NOP_CYCLE_OUT        = nop_q;

endmodule : mrid_core

// ---- tb/mrid_core_chk.sv ----
/*
  Port-level checker of the instruction decoder: cycle length, forced
  no-operation cycles, call, prescaler and watchdog side signals, standby.
  Assumes it is bound to the decoder's top module, one clock domain.
*/
`timescale 1ns/100ps

module mrid_core_chk (
  // clock and reset
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  // watched ports
  input wire logic [1:0]  PAGE_IN,
  input wire logic [12:0] PC_OUT,
  input wire logic        PUSH_OUT,
  input wire logic [12:0] RET_ADDR_OUT,
  input wire logic        PRESC_TIMER_ZERO_COUNT_IN,
  input wire logic        PRESC_CLR_OUT,
  input wire logic        WDT_CLR_OUT,
  input wire logic [7:0]  W_OUT,
  input wire logic        TIMEOUT_FLAG_OUT,
  input wire logic        POWERDOWN_FLAG_OUT,
  input wire logic        SLEEP_OUT,
  input wire logic        CYCLE_END_OUT,
  input wire logic        NOP_CYCLE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ============================================================
  // sequences
  // ============================================================
  sequence s_quiet3;
    !CYCLE_END_OUT [*3];
  endsequence
  sequence s_executes;
    CYCLE_END_OUT && !$past(NOP_CYCLE_OUT);
  endsequence
  // ============================================================
  // assertions; a cycle end is sampled one clock after its edge
  // ============================================================
  a_cycle_four_clocks: assert property (
    CYCLE_END_OUT && !SLEEP_OUT |=> s_quiet3 ##1 CYCLE_END_OUT)
    else $error("instruction cycle is not four clocks");
  a_call_then_nop: assert property (
    PUSH_OUT |-> s_executes ##0 NOP_CYCLE_OUT)
    else $error("call not followed by a no-operation cycle");
  a_call_return_addr: assert property (
    PUSH_OUT |-> RET_ADDR_OUT == $past(PC_OUT)
                 && PC_OUT[12:11] == $past(PAGE_IN))
    else $error("call return address or page wrong");
  a_skip_nop_hold: assert property (
    $rose(NOP_CYCLE_OUT) |-> NOP_CYCLE_OUT [*4])
    else $error("forced no-operation cycle shorter than four clocks");
  a_nop_no_effect: assert property (
    CYCLE_END_OUT && $past(NOP_CYCLE_OUT) |->
      $stable(W_OUT) && !PUSH_OUT && !PRESC_CLR_OUT && !WDT_CLR_OUT)
    else $error("no-operation cycle changed state");
  a_presc_clear_cause: assert property (
    PRESC_CLR_OUT |-> s_executes ##0 $past(PRESC_TIMER_ZERO_COUNT_IN))
    else $error("prescaler cleared without timer assignment");
  a_wdt_clear_flags: assert property (
    WDT_CLR_OUT |-> s_executes ##0 TIMEOUT_FLAG_OUT
                    && POWERDOWN_FLAG_OUT == !SLEEP_OUT)
    else $error("watchdog clear without timeout flag set");
  a_standby_enter: assert property (
    $rose(SLEEP_OUT) |-> WDT_CLR_OUT && TIMEOUT_FLAG_OUT
                         && !POWERDOWN_FLAG_OUT)
    else $error("standby entry flags wrong");
  a_standby_frozen: assert property (
    SLEEP_OUT && $past(SLEEP_OUT) |-> !CYCLE_END_OUT && $stable(PC_OUT))
    else $error("sequencer ran during standby");
endmodule : mrid_core_chk

bind mrid_core mrid_core_chk u_chk (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .PAGE_IN(PAGE_IN), .PC_OUT(PC_OUT),
  .PUSH_OUT(PUSH_OUT), .RET_ADDR_OUT(RET_ADDR_OUT),
  .PRESC_TIMER_ZERO_COUNT_IN(PRESC_TIMER_ZERO_COUNT_IN), .PRESC_CLR_OUT(PRESC_CLR_OUT),
  .WDT_CLR_OUT(WDT_CLR_OUT), .W_OUT(W_OUT),
  .TIMEOUT_FLAG_OUT(TIMEOUT_FLAG_OUT),
  .POWERDOWN_FLAG_OUT(POWERDOWN_FLAG_OUT), .SLEEP_OUT(SLEEP_OUT),
  .CYCLE_END_OUT(CYCLE_END_OUT), .NOP_CYCLE_OUT(NOP_CYCLE_OUT));

// ---- tb/test_mrid_core.sv ----
/*
  Self-checking testbench of the instruction decoder: a program table is
  served on the fetch address, results are compared each cycle.
  Assumes the decoder fetches one word per four clocks after reset.
*/
`timescale 1ns/100ps

module test_mrid_core;
  import mrid_pkg::*;
  // ============================================================
  // signals
  // ============================================================
  logic        clk, nrst, wake, push, pop, c, dc, z, to, pd, slp;
  logic        cend, nopc, pclr, wclr, presc;
  logic [13:0] instr;
  logic [12:0] pc, ret;
  logic [7:0]  w;
  logic [6:0]  fadr;
  logic [13:0] prog [0:63];
  logic [11:0] exp_st [1:22];
  int          fail_count;
  int          comparisons;
  int          n;

  mrid_core uut (
    .CLK_IN(clk), .NRST_IN(nrst), .INSTR_IN(instr), .PAGE_IN(2'h1),
    .PC_OUT(pc), .TOS_IN(13'h0000), .PUSH_OUT(push), .POP_OUT(pop),
    .RET_ADDR_OUT(ret), .PINS_IN(8'hA5), .PRESC_TIMER_ZERO_COUNT_IN(presc),
    .WAKE_IN(wake), .FILE_ADDR_OUT(fadr), .PRESC_CLR_OUT(pclr),
    .WDT_CLR_OUT(wclr), .W_OUT(w), .CARRY_OUT(c),
    .DIGIT_CARRY_FLAG_OUT(dc), .ZERO_OUT(z), .TIMEOUT_FLAG_OUT(to),
    .POWERDOWN_FLAG_OUT(pd), .SLEEP_OUT(slp), .CYCLE_END_OUT(cend),
    .NOP_CYCLE_OUT(nopc));

  // ============================================================
  // tasks
  // ============================================================
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, expv);
    end
  endtask : chk

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // one instruction cycle: bounded wait for the cycle-end pulse
  task automatic cyc();
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cend !== 1'b1 && i < 12);
    if (cend !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t: no cycle end", $time);
      report_and_stop();
    end
  endtask : cyc

  // ============================================================
  // clock and program fetch, both off the sampling edge
  // ============================================================
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) instr <= prog[pc[5:0]];

  // ============================================================
  // main sequence; table holds {W, 0, C, DC, Z} after each cycle
  // ============================================================
  initial begin
    prog = '{0:14'h300F, 1:14'h3FF1, 2:14'h00A0, 3:14'h3088, 4:14'h07A0,
      5:14'h0720, 6:14'h0520, 7:14'h1420, 8:14'h13A0, 9:14'h18A0,
      10:14'h30EE, 11:14'h1DA0, 12:14'h30DD, 13:14'h1D20, 14:14'h0820,
      15:14'h390C, 16:14'h01A0, 17:14'h0820, 18:14'h0081, 19:14'h0805,
      20:14'h0064, 21:14'h0063, 22:14'h281E, 30:14'h2028,
      40:14'h0081, 41:14'h3477, default:14'h0000};
    exp_st = '{12'h0F0, 12'h007, 12'h007, 12'h887, 12'h880, 12'h106,
      12'h007, 12'h007, 12'h007, 12'h007, 12'h007, 12'h007, 12'h007,
      12'h007, 12'h096, 12'h086, 12'h087, 12'h007, 12'h007, 12'hA56,
      12'hA56, 12'hA56};
    fail_count = 0;
    comparisons = 0;
    instr = 14'h0000;
    wake = 1'b0;
    presc = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    cyc();
    for (n = 1; n <= 22; n++) begin
      cyc();
      chk(w, exp_st[n][11:4]);
      chk({c, dc, z}, exp_st[n][2:0]);
      // the forced no-operation flag stands from the skip's end to the next
      if (n >= 10 && n <= 14) begin
        chk(nopc, n == 10 || n == 12);
      end
      if (n == 19) chk({pclr, fadr}, {1'b1, 7'h05});
      if (n == 21) chk({wclr, to, pd}, 3'h7);
      if (n == 22) chk({wclr, to, pd, slp}, 4'hD);
    end
    // standby holds the fetch address until woken
    repeat (8) @(negedge clk);
    chk(pc, 13'd23);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    for (n = 0; n < 4 && pc[10:0] !== 11'd30; n++) cyc();
    chk({nopc, pc}, {1'b1, 2'h1, 11'd30});
    cyc();
    cyc();
    chk({push, pc}, {1'b1, 2'h1, 11'd40});
    chk(ret, {2'h1, 11'd31});
    // timer write with the prescaler elsewhere must not clear it
    presc = 1'b0;
    cyc();
    cyc();
    chk(pclr, 1'b0);
    // literal return: pops, loads the stack top, then a forced nop
    cyc();
    chk({pop, nopc, pc}, {2'b11, 13'h0000});
    chk(w, 8'h77);
    report_and_stop();
  end
endmodule : test_mrid_core
